// ---- core/power_monitor_result_registers.sv ----
// result and calibration register bank of the shunt power monitor
`timescale 1ns/1ps
module power_monitor_result_registers
  import pmon_pkg::*;
#(
  parameter int CUR_SHIFT = 12,
  parameter int PWR_SHIFT = 13
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // host register access from the serial interface
  input  wire reg_req_t    i_req,
  output logic [15:0]      o_rdata,
  output logic             o_rvalid,
  // conversion sequencer
  input  wire meas_t       i_meas,
  input  wire logic        i_mode_wr,
  input  wire logic [2:0]  i_mode,
  // status to the rest of the device
  output logic             o_busy
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  calc_state_t        state_r;
  calc_state_t        state_nxt;
  logic [12:0]        bus_volt_r;
  logic [12:0]        pend_bus_r;
  logic signed [15:0] pend_shunt_r;
  logic signed [15:0] current_r;
  logic signed [15:0] cur_tmp_r;
  logic [15:0]        power_r;
  logic [15:0]        cal_r;
  logic               rdy_r;
  logic               ovf_r;
  logic               cur_ovf_r;
  logic [15:0]        rdata_r;
  logic               rvalid_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic sel_bus;
  logic sel_pwr;
  logic sel_cur;
  logic sel_cal;
  logic cal_wr;
  logic pwr_rd;
  logic mode_clr;
  logic set_rdy;

  assign sel_bus = i_req.addr == ADDR_BUS_VOLT;
  assign sel_pwr = i_req.addr == ADDR_POWER;
  assign sel_cur = i_req.addr == ADDR_CURRENT;
  assign sel_cal = i_req.addr == ADDR_CAL;
  assign cal_wr  = i_req.wr & sel_cal;
  assign pwr_rd  = i_req.rd & sel_pwr;
  // off modes leave the flag alone
  assign mode_clr = i_mode_wr & (i_mode != MODE_POWER_DOWN)
                    & (i_mode != MODE_DISABLE);

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // calibration value excludes void bit 0
  logic signed [16:0] cal_op;
  logic signed [16:0] shunt_op;
  logic signed [16:0] cur_op;
  logic signed [16:0] bus_op;
  logic signed [15:0] cur_res;
  logic signed [15:0] pwr_res;
  logic               cur_ovf;
  logic               pwr_ovf;
  logic signed [15:0] pwr_mag;

  assign cal_op   = {1'b0, cal_r & CAL_WR_MASK};
  assign shunt_op = {pend_shunt_r[15], pend_shunt_r};
  assign cur_op   = {cur_tmp_r[15], cur_tmp_r};
  assign bus_op   = {4'h0, pend_bus_r};

  // current = shunt * cal >> CUR_SHIFT
  sat_mul #(
    .SHIFT (CUR_SHIFT)
  ) u_cur_mul (
    .i_a   (shunt_op),
    .i_b   (cal_op),
    .o_res (cur_res),
    .o_ovf (cur_ovf)
  );

  // power = current * bus >> PWR_SHIFT
  sat_mul #(
    .SHIFT (PWR_SHIFT)
  ) u_pwr_mul (
    .i_a   (cur_op),
    .i_b   (bus_op),
    .o_res (pwr_res),
    .o_ovf (pwr_ovf)
  );

  // power register is unsigned; report magnitude
  assign pwr_mag = pwr_res[15] ? -pwr_res : pwr_res;

  // ----------------------------------------------------------------
  // sequencing: capture, current, then power and publish
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (i_meas.done) begin
          state_nxt = ST_CALC;
        end
      end
      ST_CALC: begin
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // flag set on the publish cycle, after both products exist
  assign set_rdy = state_r == ST_LOAD;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // new samples ignored while a calculation is in flight
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_bus_r   <= RST_BUS_VOLT;
      pend_shunt_r <= '0;
    end else if (state_r == ST_IDLE && i_meas.done) begin
      pend_bus_r   <= i_meas.bus_volt;
      pend_shunt_r <= i_meas.shunt;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_tmp_r <= '0;
      cur_ovf_r <= 1'b0;
    end else if (state_r == ST_CALC) begin
      cur_tmp_r <= cur_res;
      cur_ovf_r <= cur_ovf;
    end
  end

  // visible results change all together, only when complete
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_volt_r <= RST_BUS_VOLT;
      current_r  <= RST_CURRENT;
      power_r    <= RST_POWER;
      ovf_r      <= 1'b0;
    end else if (set_rdy) begin
      bus_volt_r <= pend_bus_r;
      current_r  <= cur_tmp_r;
      power_r    <= pwr_mag;
      ovf_r      <= cur_ovf_r | pwr_ovf;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rdy_r <= 1'b0;
    end else if (set_rdy) begin
      rdy_r <= 1'b1;
    end else if (pwr_rd || mode_clr) begin
      rdy_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cal_r <= RST_CAL;
    end else if (cal_wr) begin
      cal_r <= i_req.wdata & CAL_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] bus_word;
  logic [15:0] rd_mux;

  // range select does not change the 4 mV weight; field is raw
  assign bus_word = {bus_volt_r, 1'b0, rdy_r, ovf_r};

  // results, power and current are read-only: writes fall through
  assign rd_mux = sel_bus ? bus_word :
                  sel_pwr ? power_r :
                  sel_cur ? current_r :
                  sel_cal ? cal_r : 16'h0000;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= i_req.rd;
      if (i_req.rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign o_rdata  = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_busy   = state_r != ST_IDLE;
endmodule

// ---- core/pmon_pkg.sv ----
// shared constants and types for the power monitor result registers
package pmon_pkg;
  // register pointer values
  localparam logic [7:0]  ADDR_BUS_VOLT    = 8'h02;
  localparam logic [7:0]  ADDR_POWER       = 8'h03;
  localparam logic [7:0]  ADDR_CURRENT     = 8'h04;
  localparam logic [7:0]  ADDR_CAL         = 8'h05;
  // reset values
  localparam logic [15:0] RST_POWER        = 16'h0000;
  localparam logic [15:0] RST_CURRENT      = 16'h0000;
  localparam logic [15:0] RST_CAL          = 16'h0000;
  localparam logic [12:0] RST_BUS_VOLT     = 13'h0000;
  // bus voltage field layout
  localparam int          BUS_VOLT_LSB_POS = 3;
  localparam int          RDY_POS          = 1;
  localparam int          OVF_POS          = 0;
  localparam int          BUS_VOLT_W       = 13;
  // full-scale counts, 4 mV per count
  localparam logic [12:0] FS_COUNT_32V     = 13'h1f40;
  localparam logic [12:0] FS_COUNT_16V     = 13'h0fa0;
  localparam int          BUS_VOLT_LSB_MV  = 4;
  // calibration: bit 0 is void
  localparam logic [15:0] CAL_WR_MASK      = 16'hfffe;
  // operating mode codes that leave the ready flag alone
  localparam logic [2:0]  MODE_POWER_DOWN  = 3'h0;
  localparam logic [2:0]  MODE_DISABLE     = 3'h4;

  // host register access strobe group
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // completed measurement from the conversion sequencer
  typedef struct packed {
    logic               done;
    logic signed [15:0] shunt;
    logic [12:0]        bus_volt;
  } meas_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CALC = 3'b010,
    ST_LOAD = 3'b100
  } calc_state_t;
endpackage

// ---- core/sat_mul.sv ----
// signed multiply, arithmetic shift and saturation to 16 bits
`timescale 1ns/1ps
module sat_mul #(
  parameter int SHIFT = 12
) (
  // operands
  input  wire logic signed [16:0] i_a,
  input  wire logic signed [16:0] i_b,
  // result
  output logic signed [15:0]      o_res,
  output logic                    o_ovf
);
  logic signed [33:0] prod;
  logic signed [33:0] shifted;
  logic               too_big;
  logic               too_small;

  assign prod      = i_a * i_b;
  assign shifted   = prod >>> SHIFT;
  assign too_big   = shifted > 34'sd32767;
  assign too_small = shifted < -34'sd32768;
  assign o_ovf     = too_big | too_small;
  assign o_res     = too_big ? 16'sh7fff : too_small ? -16'sh8000 : shifted[15:0];
endmodule

// ---- testbench/pmon_checker.sv ----
// port assertions for the power monitor result registers
`timescale 1ns/1ps
module pmon_checker
  import pmon_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire reg_req_t    i_req,
  input  wire logic [15:0] o_rdata,
  input  wire logic        o_rvalid,
  input  wire meas_t       i_meas,
  input  wire logic        i_mode_wr,
  input  wire logic [2:0]  i_mode,
  input  wire logic        o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire logic rd_bus = i_req.rd && i_req.addr == ADDR_BUS_VOLT && !o_busy;
  wire logic rd_pwr = i_req.rd && i_req.addr == ADDR_POWER && !o_busy;
  wire logic take   = i_meas.done && !o_busy;
  // off modes must not disturb the ready flag
  wire logic mode_clr = i_mode_wr && i_mode != MODE_POWER_DOWN && i_mode != MODE_DISABLE;
  AST_RVALID_ON: assert property (i_req.rd |=> o_rvalid)
    else $error("read got no valid");
  AST_RVALID_OFF: assert property (!i_req.rd |=> !o_rvalid)
    else $error("valid without read");
  AST_RDATA_HOLD: assert property (!i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without read");
  AST_BUS_BIT2: assert property (i_req.rd && i_req.addr == ADDR_BUS_VOLT |=> !o_rdata[2])
    else $error("bus bit 2 not zero");
  AST_CAL_BIT0: assert property (i_req.rd && i_req.addr == ADDR_CAL |=> !o_rdata[0])
    else $error("cal bit 0 not zero");
  AST_CALC_SEQ: assert property (take |=> o_busy ##1 o_busy ##1 !o_busy)
    else $error("calculation length wrong");
  AST_PUB_READY: assert property (($fell(o_busy) && !rd_pwr && !mode_clr) ##1 rd_bus |=> o_rdata[1])
    else $error("ready missing after publish");
  AST_PWR_CLEAR: assert property (rd_pwr ##1 !o_busy ##1 rd_bus |=> !o_rdata[1])
    else $error("power read left ready set");
  AST_MODE_CLEAR: assert property (mode_clr && !o_busy ##1 rd_bus |=> !o_rdata[1])
    else $error("mode write left ready set");
  cover property (take);
  cover property (rd_pwr);
  cover property (mode_clr);
endmodule

bind power_monitor_result_registers pmon_checker pmon_checker_i (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_meas(i_meas), .i_mode_wr(i_mode_wr), .i_mode(i_mode), .o_busy(o_busy));

// ---- testbench/pmon_host.sv ----
// host model issuing register reads and writes
`timescale 1ns/1ps
module pmon_host
  import pmon_pkg::*;
(
  // clock
  input  wire logic        i_clock,
  // answer
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  // request
  output reg_req_t         o_req
);
  initial o_req = '{rd:1'b0, wr:1'b0, addr:8'hff, wdata:16'h0000};
  // released lines show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    o_req <= '{rd:1'b0, wr:1'b1, addr:a, wdata:d};
    @(posedge i_clock);
    o_req <= '{rd:1'b0, wr:1'b0, addr:~a, wdata:~d};
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
    int n;
    o_req <= '{rd:1'b1, wr:1'b0, addr:a, wdata:16'h0000};
    @(posedge i_clock);
    o_req <= '{rd:1'b0, wr:1'b0, addr:~a, wdata:16'hffff};
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_rvalid !== 1'b1 && n < 4);
    ok = (i_rvalid === 1'b1);
    d = i_rdata;
  endtask
endmodule

// ---- testbench/power_monitor_result_registers_bench.sv ----
// self-checking bench for the power monitor result registers
`timescale 1ns/1ps
module power_monitor_result_registers_bench;
  import pmon_pkg::*;
  localparam int CS = 12;
  localparam int PS = 13;
  logic        i_clock = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_mode_wr = 1'b0;
  logic [2:0]  i_mode = 3'h0;
  meas_t       i_meas = '0;
  reg_req_t    req;
  logic [15:0] o_rdata;
  logic        o_rvalid;
  logic        o_busy;
  int          n_errors = 0;
  int          checks = 0;
  int          cal_m = 0;
  int          cur_m = 0;
  int          pwr_m = 0;
  int          bus_m = 0;
  bit          rdy_m = 0;
  bit          ovf_m = 0;

  power_monitor_result_registers #(.CUR_SHIFT(CS), .PWR_SHIFT(PS))
    power_monitor_result_registers_i (.i_clock(i_clock), .i_rstn(i_rstn), .i_req(req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_meas(i_meas), .i_mode_wr(i_mode_wr),
    .i_mode(i_mode), .o_busy(o_busy));
  pmon_host pmon_host_i (.i_clock(i_clock), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
    .o_req(req));

  always #5 i_clock = ~i_clock;

  task automatic results;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    pmon_host_i.rd(a, d, ok);
    if (!ok) begin
      n_errors++;
      results();
    end else begin
      check(d, exp);
    end
  endtask
  function automatic int sat(input longint v);
    return v > 32767 ? 32767 : v < -32768 ? -32768 : int'(v);
  endfunction
  function automatic logic [15:0] bw();
    return {13'(bus_m), 1'b0, rdy_m, ovf_m};
  endfunction
  // dup sends a second completion while busy; it must be dropped
  task automatic measure(input logic signed [15:0] sh, input int bv, input bit dup);
    longint c;
    longint p;
    i_meas <= '{done:1'b1, shunt:sh, bus_volt:13'(bv)};
    @(posedge i_clock);
    i_meas <= '{done:dup, shunt:16'h7fff, bus_volt:13'h1fff};
    @(posedge i_clock);
    i_meas.done <= 1'b0;
    check(16'(o_busy), 16'h0001);
    repeat (2) @(posedge i_clock);
    check(16'(o_busy), 16'h0000);
    c = (longint'(sh) * cal_m) >>> CS;
    cur_m = sat(c);
    p = (longint'(cur_m) * bv) >>> PS;
    if (p < 0) p = -p;
    pwr_m = sat(p);
    ovf_m = (cur_m != c) || (pwr_m != p);
    bus_m = bv;
    rdy_m = 1'b1;
  endtask

  initial begin
    int bv;
    int cv;
    int s;
    void'($urandom(32'h3cae4fd1));
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    rd_chk(ADDR_BUS_VOLT, 16'h0000);
    rd_chk(ADDR_CAL, RST_CAL);
    rd_chk(8'h07, 16'h0000);
    pmon_host_i.wr(ADDR_POWER, 16'h1234);
    pmon_host_i.wr(ADDR_CURRENT, 16'h1234);
    rd_chk(ADDR_POWER, RST_POWER);
    rd_chk(ADDR_CURRENT, RST_CURRENT);
    for (int i = 0; i < 40; i++) begin
      cv = (i == 0) ? 16'hffff : $urandom_range(16'hffff);
      pmon_host_i.wr(ADDR_CAL, 16'(cv));
      cal_m = cv & 32'hfffe;
      rd_chk(ADDR_CAL, 16'(cal_m));
      bv = i == 1 ? FS_COUNT_32V : i == 2 ? FS_COUNT_16V : $urandom_range(8191);
      s = (int'($urandom_range(65535)) - 32768) >>> (i % 12);
      measure(16'(s), bv, i % 5 == 3);
      rd_chk(ADDR_BUS_VOLT, bw());
      rd_chk(ADDR_CURRENT, 16'(cur_m));
      i_mode <= 3'(i);
      i_mode_wr <= 1'b1;
      @(posedge i_clock);
      i_mode_wr <= 1'b0;
      rdy_m = rdy_m && (3'(i) == MODE_POWER_DOWN || 3'(i) == MODE_DISABLE);
      rd_chk(ADDR_BUS_VOLT, bw());
      rd_chk(ADDR_POWER, 16'(pwr_m));
      rdy_m = 1'b0;
      rd_chk(ADDR_BUS_VOLT, bw());
    end
    // mid-run reset must bring every result back to zero
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    rd_chk(ADDR_BUS_VOLT, 16'h0000);
    rd_chk(ADDR_POWER, RST_POWER);
    rd_chk(ADDR_CURRENT, RST_CURRENT);
    rd_chk(ADDR_CAL, RST_CAL);
    results();
  end
endmodule
